//--- core/ch6_diag_regs.sv
// Functional notes
// - gain trim code steps 0.1 dB; code 0 is -0.8 dB, code 8 is 0 dB.
// - gain trim register resets to 80h; low reserved nibble reads zero.
// - phase code delays channel 6 by that many modulator clock cycles, 0..255.
// - phase trim register at page 0 address 59h, resets to zero.
// - scan enable bits 7..2 cover channels 1..6, both pins of differential channels; bit 0 includes AC-coupled ones.
// - channel 5/6 scan enables and channel 6 trims act only on six-channel variant.
// - bit 1 includes negative pins of single-ended channels in the scan.
// - scan enable register at page 0 address 64h, resets to zero.
// - threshold register at page 0 address 65h, resets to 37h.
// - input config code 0 is differential, code 1 single-ended.
`timescale 1ns/1ns
`default_nettype none
module ch6_diag_regs (
  input  wire logic        MCLK,            // control clock, 250 MHz
  input  wire logic        RESET_N,         // async reset, active low
  input  wire logic        SIX_CH_STRAP,    // variant strap pin, high for six channels
  input  wire logic [7:0]  REG_PAGE,        // selected register page
  input  wire logic [7:0]  REG_ADDR,        // register address within page
  input  wire logic        REG_WR,          // write strobe, one cycle
  input  wire logic        REG_RD,          // read strobe, one cycle
  input  wire logic [7:0]  REG_WDATA,       // write data
  output logic      [7:0]  REG_RDATA,       // read data, valid cycle after REG_RD
  input  wire logic        MOD_CLK_EN,      // modulator clock step pulse
  input  wire logic        CH6_MOD_IN,      // channel 6 modulator sample
  output logic             CH6_MOD_OUT,     // phase-delayed channel 6 sample
  input  wire logic [11:0] CH_INPUT_CONFIG, // 2-bit input config per channel, ch1 low
  input  wire logic [5:0]  CH_AC_COUPLED,   // channel coupling is AC, ch1 at bit 0
  output logic      [5:0]  SCAN_POS,        // positive pin scanned, ch1 at bit 0
  output logic      [5:0]  SCAN_NEG,        // negative pin scanned, ch1 at bit 0
  output logic      [3:0]  GAIN_TRIM_CODE,  // effective channel 6 gain trim code
  output logic signed [4:0] GAIN_TRIM_TENTHS, // gain trim in 0.1 dB units
  output logic      [7:0]  THRESH_A         // diagnostic threshold register value
);
  logic       strap_s1_q;
  logic       strap_s2_q;
  logic       strap_s3_q;
  logic       six_ch_q;
  logic       page_hit;
  logic [7:0] gain_reg_q;
  logic [7:0] phase_reg_q;
  logic [7:0] scan_reg_q;
  logic [7:0] thresh_reg_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [5:0] scan_pos_d;
  logic [5:0] scan_neg_d;
  logic [5:0] scan_pos_q;
  logic [5:0] scan_neg_q;
  logic [3:0] gain_code_q;
  logic [4:0] gain_tenths_q;
  logic [3:0] gain_field;
  logic [7:0] phase_eff;

  assign page_hit   = (REG_PAGE == ch6_diag_pkg::PAGE_CFG);
  assign gain_field = gain_reg_q[ch6_diag_pkg::GAIN_MSB:ch6_diag_pkg::GAIN_LSB];

  // strap is asynchronous to MCLK; variant follows only once two stages agree
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      strap_s3_q <= 1'b0;
    end else begin
      strap_s1_q <= SIX_CH_STRAP;
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      six_ch_q <= 1'b0;
    end else if (strap_s2_q == strap_s3_q) begin
      six_ch_q <= strap_s3_q;
    end
  end

  // reserved low nibble is never stored, so it always reads back zero
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      gain_reg_q <= ch6_diag_pkg::RST_GAIN_TRIM;
    end else if (REG_WR && page_hit && REG_ADDR == ch6_diag_pkg::ADDR_GAIN_TRIM) begin
      gain_reg_q <= REG_WDATA & ch6_diag_pkg::GAIN_WR_MASK;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_reg_q <= ch6_diag_pkg::RST_PHASE_TRIM;
    end else if (REG_WR && page_hit && REG_ADDR == ch6_diag_pkg::ADDR_PHASE_TRIM) begin
      phase_reg_q <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scan_reg_q <= ch6_diag_pkg::RST_SCAN_EN;
    end else if (REG_WR && page_hit && REG_ADDR == ch6_diag_pkg::ADDR_SCAN_EN) begin
      scan_reg_q <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      thresh_reg_q <= ch6_diag_pkg::RST_THRESH_A;
    end else if (REG_WR && page_hit && REG_ADDR == ch6_diag_pkg::ADDR_THRESH_A) begin
      thresh_reg_q <= REG_WDATA;
    end
  end

  // registers keep what software wrote on either variant; only effects are gated
  always_comb begin
    rdata_d = 8'h00;
    if (page_hit) begin
      case (REG_ADDR)
        ch6_diag_pkg::ADDR_GAIN_TRIM:  rdata_d = gain_reg_q;
        ch6_diag_pkg::ADDR_PHASE_TRIM: rdata_d = phase_reg_q;
        ch6_diag_pkg::ADDR_SCAN_EN:    rdata_d = scan_reg_q;
        ch6_diag_pkg::ADDR_THRESH_A:   rdata_d = thresh_reg_q;
        default:                       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      rdata_q <= rdata_d;
    end
  end

  // per-channel scan selection, same shape for all six channels
  genvar ch;
  generate
    for (ch = 0; ch < ch6_diag_pkg::NUM_CH; ch++) begin : g_scan
      logic en_bit;
      logic single_ended;
      logic variant_ok;
      assign en_bit       = scan_reg_q[ch6_diag_pkg::SCAN_CH1_BIT - ch];
      assign single_ended = (CH_INPUT_CONFIG[ch*ch6_diag_pkg::INCFG_W +: ch6_diag_pkg::INCFG_W]
                             == ch6_diag_pkg::INCFG_SINGLE);
      assign variant_ok   = six_ch_q || (ch < ch6_diag_pkg::CH5_IDX);
      assign scan_pos_d[ch] = en_bit && variant_ok &&
                              (!CH_AC_COUPLED[ch] || scan_reg_q[ch6_diag_pkg::SCAN_AC_BIT]);
      assign scan_neg_d[ch] = scan_pos_d[ch] &&
                              (!single_ended || scan_reg_q[ch6_diag_pkg::SCAN_SE_NEG_BIT]);
    end
  endgenerate

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scan_pos_q <= 6'h00;
      scan_neg_q <= 6'h00;
    end else begin
      scan_pos_q <= scan_pos_d;
      scan_neg_q <= scan_neg_d;
    end
  end

  // four-channel parts hold the trim at its 0 dB code
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      gain_code_q   <= ch6_diag_pkg::GAIN_ZERO_DB_CODE[3:0];
      gain_tenths_q <= 5'h00;
    end else if (six_ch_q) begin
      gain_code_q   <= gain_field;
      gain_tenths_q <= {1'b0, gain_field} - ch6_diag_pkg::GAIN_ZERO_DB_CODE;
    end else begin
      gain_code_q   <= ch6_diag_pkg::GAIN_ZERO_DB_CODE[3:0];
      gain_tenths_q <= 5'h00;
    end
  end

  assign phase_eff = six_ch_q ? phase_reg_q : 8'h00;

  phase_delay_line u_phase (
    .clk     (MCLK),
    .rst_n   (RESET_N),
    .step_en (MOD_CLK_EN),
    .delay   (phase_eff),
    .din     (CH6_MOD_IN),
    .dout    (CH6_MOD_OUT)
  );

  assign REG_RDATA        = rdata_q;
  assign SCAN_POS         = scan_pos_q;
  assign SCAN_NEG         = scan_neg_q;
  assign GAIN_TRIM_CODE   = gain_code_q;
  assign GAIN_TRIM_TENTHS = gain_tenths_q;
  assign THRESH_A         = thresh_reg_q;

  chk_gain_tenths: assert property (@(posedge MCLK) disable iff (!RESET_N)
    six_ch_q |=> GAIN_TRIM_TENTHS == $signed({1'b0, $past(gain_field)}) - 5'sd8)
    else $error("gain trim tenths not code minus eight");

  chk_gain_reserved: assert property (@(posedge MCLK) disable iff (!RESET_N)
    REG_RD && page_hit && REG_ADDR == ch6_diag_pkg::ADDR_GAIN_TRIM |=> REG_RDATA[3:0] == 4'h0)
    else $error("reserved gain trim bits read nonzero");

  chk_phase_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
    REG_WR && page_hit && REG_ADDR == ch6_diag_pkg::ADDR_PHASE_TRIM ##1 !REG_WR ##1 REG_RD && !REG_WR
      && page_hit && REG_ADDR == ch6_diag_pkg::ADDR_PHASE_TRIM |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("phase trim readback differs from written value");

  chk_scan_pos: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !scan_reg_q[ch6_diag_pkg::SCAN_CH1_BIT] |=> !SCAN_POS[0])
    else $error("channel 1 scanned while its enable is clear");

  chk_variant_gate: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !six_ch_q |=> SCAN_POS[ch6_diag_pkg::CH6_IDX:ch6_diag_pkg::CH5_IDX] == 2'b00
      && GAIN_TRIM_CODE == ch6_diag_pkg::GAIN_ZERO_DB_CODE[3:0])
    else $error("channel 5 or 6 features active on four-channel variant");

  chk_neg_excl: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !scan_reg_q[ch6_diag_pkg::SCAN_SE_NEG_BIT] && CH_INPUT_CONFIG[1:0] == ch6_diag_pkg::INCFG_SINGLE
      |=> !SCAN_NEG[0])
    else $error("single-ended negative pin scanned while excluded");

  chk_diff_neg: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CH_INPUT_CONFIG[1:0] == ch6_diag_pkg::INCFG_DIFF |=> SCAN_NEG[0] == SCAN_POS[0])
    else $error("differential channel pins not scanned together");

  chk_thresh_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
    REG_RD && page_hit && REG_ADDR == ch6_diag_pkg::ADDR_THRESH_A |=> REG_RDATA == $past(thresh_reg_q))
    else $error("threshold register readback mismatch");

  chk_ac_excl: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CH_AC_COUPLED[0] && !scan_reg_q[ch6_diag_pkg::SCAN_AC_BIT] |=> !SCAN_POS[0] && !SCAN_NEG[0])
    else $error("ac-coupled channel scanned while excluded");
endmodule
`default_nettype wire

//--- core/phase_delay_line.sv
`timescale 1ns/1ns
`default_nettype none
module phase_delay_line (
  input  wire logic       clk,     // control clock
  input  wire logic       rst_n,   // async reset, active low
  input  wire logic       step_en, // one modulator clock cycle
  input  wire logic [7:0] delay,   // delay in modulator cycles
  input  wire logic       din,     // modulator sample in
  output logic            dout     // delayed sample
);
  logic [0:0] mem [ch6_diag_pkg::DELAY_DEPTH];
  logic [7:0] wr_ptr_q;
  logic [7:0] rd_ptr;
  logic       dout_q;

  // history slot written exactly delay steps ago
  assign rd_ptr = wr_ptr_q - delay;
  assign dout   = dout_q;

  always_ff @(posedge clk) begin
    if (step_en) begin
      mem[wr_ptr_q] <= din;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 8'h00;
    end else if (step_en) begin
      wr_ptr_q <= wr_ptr_q + 8'h01;
    end
  end

  // code zero bypasses the memory so no stale slot leaks out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= 1'b0;
    end else if (step_en) begin
      dout_q <= (delay == 8'h00) ? din : mem[rd_ptr][0];
    end
  end

  chk_zero_delay: assert property (@(posedge clk) disable iff (!rst_n)
    step_en && delay == 8'h00 |=> dout == $past(din))
    else $error("zero phase code did not pass sample straight through");

  chk_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
    step_en |=> wr_ptr_q == $past(wr_ptr_q) + 8'h01)
    else $error("delay line write pointer did not advance one slot");
endmodule
`default_nettype wire

//--- shared/ch6_diag_pkg.sv
`default_nettype none
package ch6_diag_pkg;
  localparam logic [7:0] PAGE_CFG          = 8'h00;
  localparam logic [7:0] ADDR_GAIN_TRIM    = 8'h58;
  localparam logic [7:0] ADDR_PHASE_TRIM   = 8'h59;
  localparam logic [7:0] ADDR_SCAN_EN      = 8'h64;
  localparam logic [7:0] ADDR_THRESH_A     = 8'h65;
  localparam logic [7:0] RST_GAIN_TRIM     = 8'h80;
  localparam logic [7:0] RST_PHASE_TRIM    = 8'h00;
  localparam logic [7:0] RST_SCAN_EN       = 8'h00;
  localparam logic [7:0] RST_THRESH_A      = 8'h37;
  // gain trim field sits in the upper nibble, lower nibble reserved
  localparam int         GAIN_MSB          = 7;
  localparam int         GAIN_LSB          = 4;
  localparam logic [4:0] GAIN_ZERO_DB_CODE = 5'h08;
  localparam logic [7:0] GAIN_WR_MASK      = 8'hf0;
  // scan enable layout: channel 1 at bit 7 down to channel 6 at bit 2
  localparam int         NUM_CH            = 6;
  localparam int         SCAN_CH1_BIT      = 7;
  localparam int         SCAN_SE_NEG_BIT   = 1;
  localparam int         SCAN_AC_BIT       = 0;
  localparam int         CH5_IDX           = 4;
  localparam int         CH6_IDX           = 5;
  // per-channel input configuration codes
  localparam logic [1:0] INCFG_DIFF        = 2'h0;
  localparam logic [1:0] INCFG_SINGLE      = 2'h1;
  localparam int         INCFG_W           = 2;
  localparam int         DELAY_DEPTH       = 256;
endpackage
`default_nettype wire

//--- verification/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic       MCLK,      // control clock
  output logic      [7:0] REG_PAGE,  // page of access
  output logic      [7:0] REG_ADDR,  // register address
  output logic            REG_WR,    // write strobe
  output logic            REG_RD,    // read strobe
  output logic      [7:0] REG_WDATA  // write data
);
  logic [7:0] exp_q[$];
  initial begin
    REG_PAGE  = 8'h00;
    REG_ADDR  = 8'h00;
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    REG_WDATA = 8'h00;
  end
  // released data goes inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    #1;
    REG_PAGE  = pg;
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WR    = 1'b1;
    @(posedge MCLK);
    #1;
    REG_WR    = 1'b0;
    REG_WDATA = ~d;
  endtask
  task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] e);
    @(posedge MCLK);
    #1;
    exp_q.push_back(e);
    REG_PAGE = pg;
    REG_ADDR = a;
    REG_RD   = 1'b1;
    @(posedge MCLK);
    #1;
    REG_RD   = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_ch6_diag_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ch6_diag_regs;
  logic        MCLK = 1'b0, RESET_N = 1'b0, SIX_CH_STRAP = 1'b1, MOD_CLK_EN = 1'b0, CH6_MOD_IN = 1'b0;
  logic [11:0] CH_INPUT_CONFIG = 12'h000;
  logic [5:0]  CH_AC_COUPLED = 6'h00, SCAN_POS, SCAN_NEG;
  logic [7:0]  REG_PAGE, REG_ADDR, REG_WDATA, REG_RDATA, THRESH_A;
  logic        REG_WR, REG_RD, CH6_MOD_OUT, rd_seen = 1'b0;
  logic [3:0]  GAIN_TRIM_CODE;
  logic signed [4:0] GAIN_TRIM_TENTHS;
  logic [31:0] lfsr = 32'h0150;
  int          errors = 0, n_checks = 0, k;
  always #2 MCLK = ~MCLK;
  host_model host (.MCLK(MCLK), .REG_PAGE(REG_PAGE), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
                   .REG_WDATA(REG_WDATA));
  ch6_diag_regs dut (.MCLK(MCLK), .RESET_N(RESET_N), .SIX_CH_STRAP(SIX_CH_STRAP), .REG_PAGE(REG_PAGE),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .MOD_CLK_EN(MOD_CLK_EN), .CH6_MOD_IN(CH6_MOD_IN), .CH6_MOD_OUT(CH6_MOD_OUT),
    .CH_INPUT_CONFIG(CH_INPUT_CONFIG), .CH_AC_COUPLED(CH_AC_COUPLED), .SCAN_POS(SCAN_POS), .SCAN_NEG(SCAN_NEG),
    .GAIN_TRIM_CODE(GAIN_TRIM_CODE), .GAIN_TRIM_TENTHS(GAIN_TRIM_TENTHS), .THRESH_A(THRESH_A));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] e, input string m);
    n_checks++;
    if (got !== e) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // read data lands one edge after the strobe is taken
  always @(posedge MCLK) rd_seen <= REG_RD;
  always @(negedge MCLK) if (rd_seen) chk(REG_RDATA, host.exp_q.pop_front(), "read");
  task automatic scan(input logic six);
    logic [7:0] en;
    logic [5:0] p, n;
    int c;
    lfsr = nxt(lfsr);
    en = lfsr[7:0];
    CH_AC_COUPLED = lfsr[13:8];
    CH_INPUT_CONFIG = lfsr[25:14];
    for (c = 0; c < 6; c++) begin
      p[c] = en[7-c] & (six | c < 4) & (~CH_AC_COUPLED[c] | en[0]);
      n[c] = p[c] & (CH_INPUT_CONFIG[2*c+:2] != 2'h1 | en[1]);
    end
    host.wr(8'h00, 8'h64, en);
    repeat (3) @(posedge MCLK);
    #1;
    chk({2'h0, SCAN_POS}, {2'h0, p}, "scan pos");
    chk({2'h0, SCAN_NEG}, {2'h0, n}, "scan neg");
  endtask
  task automatic phase(input logic [7:0] n, input logic six);
    logic h[$];
    logic en, d;
    int j;
    host.wr(8'h00, 8'h59, n);
    host.rd(8'h00, 8'h59, n);
    for (j = 0; j < 700; j++) begin
      lfsr = nxt(lfsr);
      en = lfsr[0] | lfsr[3];
      d = lfsr[5];
      MOD_CLK_EN = en;
      CH6_MOD_IN = d;
      @(posedge MCLK);
      #1;
      if (en) begin
        h.push_front(d);
        if (h.size() > (six ? n : 0)) chk({7'h0, CH6_MOD_OUT}, {7'h0, h[six ? n : 0]}, "phase");
      end
    end
    MOD_CLK_EN = 1'b0;
  endtask
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge MCLK);
    #1;
    RESET_N = 1'b1;
    repeat (6) @(posedge MCLK);
    host.rd(8'h00, 8'h58, 8'h80);
    host.rd(8'h00, 8'h59, 8'h00);
    host.rd(8'h00, 8'h64, 8'h00);
    host.rd(8'h00, 8'h65, 8'h37);
    chk({4'h0, GAIN_TRIM_CODE}, 8'h08, "gain reset");
    chk(THRESH_A, 8'h37, "thresh reset");
    $display("reset values done");
    for (k = 0; k < 16; k++) begin
      lfsr = nxt(lfsr);
      host.wr(8'h00, 8'h58, {k[3:0], lfsr[3:0]});
      host.rd(8'h00, 8'h58, {k[3:0], 4'h0});
      chk({4'h0, GAIN_TRIM_CODE}, {4'h0, k[3:0]}, "gain code");
      chk({{3{GAIN_TRIM_TENTHS[4]}}, GAIN_TRIM_TENTHS}, 8'(k - 8), "gain tenths");
    end
    $display("gain trim done");
    lfsr = nxt(lfsr);
    host.wr(8'h00, 8'h65, lfsr[7:0]);
    host.wr(8'h01, 8'h65, ~lfsr[7:0]);
    host.rd(8'h00, 8'h65, lfsr[7:0]);
    host.rd(8'h00, 8'h60, 8'h00);
    host.rd(8'h01, 8'h64, 8'h00);
    chk(THRESH_A, lfsr[7:0], "thresh");
    $display("map done");
    for (k = 0; k < 16; k++) scan(1'b1);
    phase(8'h00, 1'b1);
    phase(8'h01, 1'b1);
    phase(8'hff, 1'b1);
    $display("six channel done");
    SIX_CH_STRAP = 1'b0;
    repeat (6) @(posedge MCLK);
    #1;
    chk({4'h0, GAIN_TRIM_CODE}, 8'h08, "gain gated");
    chk({3'h0, GAIN_TRIM_TENTHS}, 8'h00, "tenths gated");
    host.rd(8'h00, 8'h58, 8'hf0);
    for (k = 0; k < 8; k++) scan(1'b0);
    phase(8'h05, 1'b0);
    $display("four channel done");
    end_of_test();
  end
endmodule
`default_nettype wire
